// [common/iowd_pkg.sv]
// Package for the I/O port watchdog: port address, field layout, timing.
// Assumes a single 125 MHz core clock.
package iowd_pkg;

  // Host I/O cycle carried into the block
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } iowd_io_req_t;

  localparam logic [15:0] IOWD_CTRL_ADDR  = 16'h0455;
  localparam int          IOWD_ARM_BIT    = 7;
  localparam logic [7:0]  IOWD_CTRL_RESET = 8'h00;

  // Timing
  localparam longint IOWD_CLK_HZ      = 125000000;
  localparam longint IOWD_TIMEOUT_MS  = 1100;
  localparam longint IOWD_TIMEOUT_CYC =
    (IOWD_TIMEOUT_MS * IOWD_CLK_HZ) / 1000;
  localparam int     IOWD_CNT_W       = 28;
  localparam int     IOWD_RST_PULSE   = 16;

endpackage : iowd_pkg

// [rtl/iowd_watchdog.sv]
// I/O port watchdog: one control byte at port 0x455, board reset output.
// Assumes host I/O cycles arrive as one-cycle strobes on core_clk_i;
// the enable strap is a pin and is synchronised here.
//
// What this block does, and what host software should do
// RULE1 - While armed, an expired countdown pulses the board reset output.
// RULE2 - The countdown lasts nominally 1.1 s, within 550 ms to 1.65 s.
// RULE3 - Host software should refresh about every 275 ms.
// RULE4 - With the enable input low the port is not decoded, no reset occurs.
// RULE5 - Raising the enable input does not arm the timer.
// RULE6 - Writing the port with bit 7 set arms the timer and starts counting.
// RULE7 - Writing the port with bit 7 clear disarms the timer.
// RULE8 - Every read of the port refreshes the timer and returns the byte.
// RULE9 - Host software should read-modify-write, touching only bit 7.
// RULE10 - Host software must refresh at most every 550 ms once armed.
// RULE11 - Bit 7 reads 1 when armed and 0 when disarmed; bits 6..0 read 0.
// RULE12 - A refresh or an arming write restarts the full countdown.
// RULE13 - After any board reset the timer comes up disarmed.
`timescale 1ns/1ps
module iowd_watchdog
  import iowd_pkg::*;
#(
  parameter longint TIMEOUT_CYC = IOWD_TIMEOUT_CYC
) (
  // Clock and reset
  input  wire logic                   core_clk_i,
  input  wire logic                   sys_rst_i,
  // Configuration strap
  input  wire logic                   wd_enable_i,
  // Host I/O cycle
  input  wire iowd_pkg::iowd_io_req_t io_req_i,
  output logic [7:0]                  io_rdata_o,
  output logic                        io_hit_o,
  // Board reset request and arm status
  output logic                        board_rst_o,
  output logic                        armed_o
);
  import iowd_pkg::*;

  localparam logic [IOWD_CNT_W-1:0] LOAD_VAL =
    IOWD_CNT_W'(TIMEOUT_CYC - 1);

  logic                  en_meta_r;
  logic                  en_sync_r;
  logic                  armed_r;
  logic [IOWD_CNT_W-1:0] cnt_r;
  logic [IOWD_CNT_W-1:0] cnt_nxt;
  logic [4:0]            pulse_r;
  logic [7:0]            io_rdata_r;
  logic                  io_hit_r;
  logic                  board_rst_r;

  wire sel     = en_sync_r && (io_req_i.addr == IOWD_CTRL_ADDR); // RULE4
  wire rd_hit  = sel && io_req_i.rd;
  wire wr_hit  = sel && io_req_i.wr;
  wire arm_wr  = wr_hit && io_req_i.wdata[IOWD_ARM_BIT]; // RULE6
  wire dis_wr  = wr_hit && !io_req_i.wdata[IOWD_ARM_BIT]; // RULE7
  wire restart = rd_hit || arm_wr; // RULE12
  wire expire  = armed_r && en_sync_r && (cnt_r == '0) && !restart; // RULE1
  wire [7:0] ctrl_val = {armed_r, 7'h00}; // RULE11

  assign cnt_nxt = restart ? LOAD_VAL :
                   (cnt_r != '0) ? cnt_r - 1'b1 : cnt_r; // RULE2

  // Strap sync: first stage read only by the second
  always_ff @(posedge core_clk_i) begin
    en_meta_r <= sys_rst_i ? 1'b0 : wd_enable_i;
    en_sync_r <= sys_rst_i ? 1'b0 : en_meta_r;
  end

  // Arm state; strap alone never arms, so reset value stays clear
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i || !en_sync_r) begin
      armed_r <= 1'b0; // RULE13 RULE5
    end else if (arm_wr) begin
      armed_r <= 1'b1; // RULE6
    end else if (dis_wr || expire) begin
      armed_r <= 1'b0; // RULE7
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      cnt_r <= LOAD_VAL;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // Stretched reset pulse so the board reset logic sees it
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      pulse_r     <= 5'h00;
      board_rst_r <= 1'b0;
    end else begin
      if (expire) begin
        pulse_r <= 5'(IOWD_RST_PULSE); // RULE1
      end else if (pulse_r != 5'h00) begin
        pulse_r <= pulse_r - 5'h01;
      end
      board_rst_r <= expire || (pulse_r > 5'h01);
    end
  end

  // Read data registered one cycle after the strobe
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      io_rdata_r <= IOWD_CTRL_RESET;
      io_hit_r   <= 1'b0;
    end else begin
      io_rdata_r <= rd_hit ? ctrl_val : 8'h00; // RULE8 RULE11
      io_hit_r   <= rd_hit || wr_hit;
    end
  end

  assign io_rdata_o  = io_rdata_r;
  assign io_hit_o    = io_hit_r;
  assign board_rst_o = board_rst_r;
  assign armed_o     = armed_r;

endmodule : iowd_watchdog

// [tb/iowd_chk.sv]
// Checker bound to the watchdog top.
// Assumes one clock; TIMEOUT_CYC is handed on by the bind.
`timescale 1ns/1ps
module iowd_chk import iowd_pkg::*; #(parameter longint TIMEOUT_CYC = 50) (
  input wire logic         core_clk_i, sys_rst_i, wd_enable_i,
  input wire iowd_io_req_t io_req_i,
  input wire logic [7:0]   io_rdata_o,
  input wire logic         io_hit_o, board_rst_o, armed_o);
  logic [31:0] gap_r;
  // Cycles since the last claimed access
  always_ff @(posedge core_clk_i) gap_r <= io_hit_o ? 32'h1 : gap_r + 32'h1;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  a_rsvd_zero: assert property (io_rdata_o[6:0] == 7'h00) else $error("d");
  a_strap_off: assert property (!wd_enable_i [*4] |-> !armed_o && !io_hit_o)
    else $error("e");
  a_arm_cause: assert property ($rose(armed_o) |-> io_hit_o) else $error("a");
  a_arm_wr: assert property (io_hit_o && $past(io_req_i.wr && io_req_i.wdata[7])
    |-> armed_o) else $error("w");
  a_disarm_wr: assert property (io_hit_o && $past(io_req_i.wr &&
    !io_req_i.wdata[7]) |-> !armed_o) else $error("c");
  a_read_bit: assert property (io_hit_o && !$past(io_req_i.wr)
    |-> io_rdata_o[7] == armed_o) else $error("r");
  a_expiry_at: assert property ($rose(board_rst_o) |-> gap_r == 32'(TIMEOUT_CYC)
    && $past(armed_o) && !armed_o) else $error("x");
  a_pulse_len: assert property ($rose(board_rst_o) |-> board_rst_o [*8] ##1
    board_rst_o [*8] ##1 !board_rst_o) else $error("p");
  cover property ($rose(board_rst_o));
  cover property (io_hit_o && io_rdata_o[7]);
  cover property ($fell(armed_o) && io_hit_o);
endmodule : iowd_chk
bind iowd_watchdog iowd_chk #(.TIMEOUT_CYC(TIMEOUT_CYC)) chk_u (.core_clk_i,
  .sys_rst_i, .wd_enable_i, .io_req_i, .io_rdata_o, .io_hit_o, .board_rst_o,
  .armed_o);

// [tb/iowd_host.sv]
// Host software model: one-cycle I/O strobes.
// Assumes requests are driven at the falling edge.
`timescale 1ns/1ps
module iowd_host import iowd_pkg::*; (
  input  wire logic             core_clk_i,
  output iowd_pkg::iowd_io_req_t io_req_o);
  initial io_req_o = '0;
  task automatic io(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(negedge core_clk_i) io_req_o = '{!w, w, a, d};
    @(negedge core_clk_i) io_req_o = '0;
  endtask : io
endmodule : iowd_host

// [tb/tb.sv]
// Bench: row table, then refresh, expiry and strap cases.
// Assumes iowd_chk binds itself to the design.
`timescale 1ns/1ps
module tb;
  import iowd_pkg::*;
  localparam int TO = 50;
  typedef struct {logic w; logic [15:0] a; logic [7:0] d; logic [2:0] x;} iowd_row_t;
  iowd_row_t rows[5] = '{'{0, 16'h0455, 8'h00, 3'h1}, '{1, 16'h0455, 8'h80, 3'h3},
    '{0, 16'h0455, 8'h00, 3'h7}, '{0, 16'h0456, 8'h00, 3'h2},
    '{1, 16'h0455, 8'h00, 3'h1}};
  logic core_clk_i = 0, sys_rst_i = 1, wd_enable_i = 1, hit, brst, armed;
  iowd_io_req_t req;
  logic [7:0] rdata;
  int bad_count = 0, checks_done = 0, cyc = 0, n;
  iowd_host host_u (.core_clk_i, .io_req_o(req));
  iowd_watchdog #(.TIMEOUT_CYC(TO)) dut_u (.core_clk_i, .sys_rst_i,
    .wd_enable_i, .io_req_i(req), .io_rdata_o(rdata), .io_hit_o(hit),
    .board_rst_o(brst), .armed_o(armed));
  always #4 core_clk_i = ~core_clk_i;
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    checks_done++;
    if (s !== e) begin
      bad_count++;
      $display("BAD %0t %h %h", $time, s, e);
    end
  endtask : chk
  task automatic report_and_stop;
    $display("checks %0d bad %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : report_and_stop
  always @(posedge core_clk_i) if (++cyc == 1000) begin
    bad_count++;
    report_and_stop();
  end
  initial begin
    repeat (6) @(negedge core_clk_i);
    sys_rst_i = 0;
    chk(8'({brst, armed, hit}), 8'h00);
    repeat (3) @(negedge core_clk_i);
    foreach (rows[i]) begin
      host_u.io(rows[i].w, rows[i].a, rows[i].d);
      chk(8'({rdata[7], armed, hit}), 8'(rows[i].x));
    end
    $display("rows done");
    host_u.io(1, 16'h0455, 8'h80);
    // Refresh well inside the shortest allowed period
    repeat (4) begin
      repeat (TO / 4) @(negedge core_clk_i);
      host_u.io(0, 16'h0455, 8'h00);
    end
    chk(8'({brst, armed}), 8'h01);
    for (n = 0; !brst && n < 99; n++) @(negedge core_clk_i);
    chk(8'(n), 8'(TO));
    $display("expiry done");
    host_u.io(1, 16'h0455, 8'h80);
    wd_enable_i = 0;
    repeat (TO + 9) @(negedge core_clk_i);
    host_u.io(0, 16'h0455, 8'h00);
    chk(8'({brst, armed, hit}), 8'h00);
    wd_enable_i = 1;
    repeat (4) @(negedge core_clk_i);
    chk(8'({brst, armed}), 8'h00);
    $display("strap done");
    host_u.io(1, 16'h0455, 8'h80);
    sys_rst_i = 1;
    repeat (2) @(negedge core_clk_i);
    sys_rst_i = 0;
    repeat (3) @(negedge core_clk_i);
    chk(8'({brst, armed, hit}), 8'h00);
    $display("reset done");
    report_and_stop();
  end
endmodule : tb
